// ==== macrst_pkg.sv ====
// shared constants for the mac reset and build configuration block
package macrst_pkg;
  // mac variant codes
  localparam int VARIANT_SOFT_10_100 = 0;
  localparam int VARIANT_SOFT_TRI = 1;
  localparam int VARIANT_HARD = 2;
  // phy interface codes
  localparam int PHY_MII = 0;
  localparam int PHY_GMII_MII = 1;
  localparam int PHY_RESERVED = 2;
  localparam int PHY_RGMII = 3;
  localparam int PHY_SGMII = 4;
  localparam int PHY_BASEX = 5;
  // checksum offload codes
  localparam int CSUM_NONE = 0;
  localparam int CSUM_PARTIAL = 1;
  localparam int CSUM_FULL = 2;
  // register bus widths
  localparam int REGBUS_DATA_WIDTH = 32;
  localparam int REGBUS_ADDR_WIDTH = 32;
  localparam int REGBUS_ID_WIDTH = 4;
  // defaults
  localparam int DEFAULT_VARIANT = 0;
  localparam int DEFAULT_PHY_TYPE = 1;
  localparam logic [4:0] DEFAULT_PHY_ADDR = 5'h01;
  localparam logic [4:0] BROADCAST_PHY_ADDR = 5'h00;
  localparam int DEFAULT_BUFFER_BYTES = 4096;
  localparam int MIN_BUFFER_BYTES = 2048;
  localparam int MAX_BUFFER_BYTES = 32768;
  localparam int STATS_WIDTH = 64;
  // reset timing
  localparam int SETTLE_CYCLES = 30;
  localparam int SYS_CLK_MHZ = 50;
  localparam int PHY_RESET_MS = 10;
  localparam int PHY_BLOCK_MS = 5;
  localparam int PHY_RESET_CYCLES = PHY_RESET_MS * SYS_CLK_MHZ * 1000;
  localparam int PHY_BLOCK_CYCLES = PHY_BLOCK_MS * SYS_CLK_MHZ * 1000;
  localparam int SIM_RESET_CYCLES = 64;
  // slow mii clock for 10 mb/s
  localparam int SLOW_CLK_KHZ = 2500;
  localparam int SLOW_DIV_HALF = SYS_CLK_MHZ * 1000 / SLOW_CLK_KHZ / 2;
endpackage

// ==== macrst_core.sv ====
// reset sequencing, clock select and build configuration of the mac
//
// What this block does
// - any of six low resets resets mac
// - each reset synchronised into every clock domain
// - 10 mb/s runs mac interface at 2.5 mhz
// - gmii transmit clock select registered from synchronised pin, may change at any time
// - register bus 32 data, 32 address, 4 id
// - variant 0 soft 10/100, 1 tri, 2 hard
// - phy type 0..5 encoding, default gmii/mii
// - phy address 1..31, default 1
// - tx and rx buffers sized 2k..32k
// - per direction checksum none, partial, full
// - vlan insert, translate, strip per direction
// - optional extended multicast filter on receive
// - statistics counters 64 bits when included
// - simulation option shortens reset durations
// - full duplex only, collision ignored
// - serdes flavour only for tri with 4/5
// - pin buffer option ignored for internal pcs
// - phy reset held 10 ms then 5 ms block
`timescale 1ns/1ps
module macrst_core #(
  parameter int mac_variant_select = macrst_pkg::DEFAULT_VARIANT,
  parameter int phy_interface_select = macrst_pkg::DEFAULT_PHY_TYPE,
  parameter logic [4:0] internal_phy_mgmt_address = macrst_pkg::DEFAULT_PHY_ADDR,
  parameter int tx_buffer_bytes = macrst_pkg::DEFAULT_BUFFER_BYTES,
  parameter int rx_buffer_bytes = macrst_pkg::DEFAULT_BUFFER_BYTES,
  parameter int tx_checksum_offload = macrst_pkg::CSUM_NONE,
  parameter int rx_checksum_offload = macrst_pkg::CSUM_NONE,
  parameter bit tx_tag_insert_en = 1'b0,
  parameter bit rx_tag_insert_en = 1'b0,
  parameter bit tx_tag_translate_en = 1'b0,
  parameter bit rx_tag_translate_en = 1'b0,
  parameter bit tx_tag_strip_en = 1'b0,
  parameter bit rx_tag_strip_en = 1'b0,
  parameter bit extended_group_filter_en = 1'b0,
  parameter bit statistics_en = 1'b0,
  parameter int statistics_counter_width = macrst_pkg::STATS_WIDTH,
  parameter bit timed_media_mode_en = 1'b0,
  parameter bit simulation_en = 1'b0,
  parameter bit include_pin_buffers = 1'b1,
  parameter bit serdes_flavour_select = 1'b0,
  parameter int regbus_id_width = macrst_pkg::REGBUS_ID_WIDTH,
  parameter int phy_reset_cycles = macrst_pkg::PHY_RESET_CYCLES,
  parameter int phy_block_cycles = macrst_pkg::PHY_BLOCK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic tx_data_stream_reset_n,
  input wire logic tx_ctrl_stream_reset_n,
  input wire logic rx_data_stream_reset_n,
  input wire logic rx_status_stream_reset_n,
  input wire logic regbus_reset_n,
  input wire logic gigabit_mode,
  input wire logic ten_mb_mode,
  input wire logic phy_collision,
  input wire logic phy_carrier_sense,
  input wire logic mgmt_data_in,
  output logic mac_reset_sys,
  output logic mac_reset_link,
  output logic access_ready,
  output logic phy_reset_out_n,
  output logic phy_access_ready,
  output logic gigabit_clk_sel,
  output logic slow_mac_clk,
  output logic mgmt_data_eff,
  output logic serdes_flavour_eff,
  output logic pin_buffers_eff,
  output logic [4:0] phy_addr_out
);
  localparam bit internal_pcs = (mac_variant_select == macrst_pkg::VARIANT_SOFT_TRI) &&
    (phy_interface_select == macrst_pkg::PHY_SGMII || phy_interface_select == macrst_pkg::PHY_BASEX);
  localparam int rst_cycles = simulation_en ? macrst_pkg::SIM_RESET_CYCLES : phy_reset_cycles;
  localparam int blk_cycles = simulation_en ? macrst_pkg::SIM_RESET_CYCLES : phy_block_cycles;
  localparam int cnt_w = $clog2(rst_cycles + blk_cycles + 1);

  // elaboration checks on the build options
  initial begin
    if (mac_variant_select < 0 || mac_variant_select > 2)
      $error("bad mac variant");
    if (phy_interface_select < 0 || phy_interface_select > 5 ||
        phy_interface_select == macrst_pkg::PHY_RESERVED)
      $error("bad phy interface");
    if (mac_variant_select == macrst_pkg::VARIANT_SOFT_10_100 && phy_interface_select != macrst_pkg::PHY_MII)
      $error("soft 10/100 needs mii");
    if (mac_variant_select != macrst_pkg::VARIANT_HARD && phy_interface_select >= macrst_pkg::PHY_RGMII &&
        mac_variant_select != macrst_pkg::VARIANT_SOFT_TRI)
      $error("interface needs tri-mode");
    if (internal_phy_mgmt_address == macrst_pkg::BROADCAST_PHY_ADDR)
      $error("phy address zero is broadcast");
    if (tx_buffer_bytes < macrst_pkg::MIN_BUFFER_BYTES || tx_buffer_bytes > macrst_pkg::MAX_BUFFER_BYTES ||
        (tx_buffer_bytes & (tx_buffer_bytes - 1)) != 0)
      $error("bad tx buffer size");
    if (rx_buffer_bytes < macrst_pkg::MIN_BUFFER_BYTES || rx_buffer_bytes > macrst_pkg::MAX_BUFFER_BYTES ||
        (rx_buffer_bytes & (rx_buffer_bytes - 1)) != 0)
      $error("bad rx buffer size");
    if (tx_checksum_offload > macrst_pkg::CSUM_FULL || rx_checksum_offload > macrst_pkg::CSUM_FULL ||
        tx_checksum_offload < 0 || rx_checksum_offload < 0)
      $error("bad checksum option");
    if (statistics_en && statistics_counter_width != macrst_pkg::STATS_WIDTH)
      $error("statistics width must be 64");
    if (timed_media_mode_en && mac_variant_select == macrst_pkg::VARIANT_HARD)
      $error("timed media mode not with hard mac");
    if (regbus_id_width != macrst_pkg::REGBUS_ID_WIDTH)
      $error("register bus id width must be 4");
  end

  // any domain reset low means the whole mac resets
  logic any_reset_n;
  assign any_reset_n = rst_n & tx_data_stream_reset_n & tx_ctrl_stream_reset_n &
    rx_data_stream_reset_n & rx_status_stream_reset_n & regbus_reset_n;

  // async assert, sync release into system domain
  logic [1:0] sys_rst_sync_reg;
  always_ff @(posedge sys_clk or negedge any_reset_n) begin
    if (!any_reset_n)
      sys_rst_sync_reg <= 2'b00;
    else
      sys_rst_sync_reg <= {sys_rst_sync_reg[0], 1'b1};
  end

  // async assert, sync release into link domain
  logic [1:0] link_rst_sync_reg;
  always_ff @(posedge link_clk or negedge any_reset_n) begin
    if (!any_reset_n)
      link_rst_sync_reg <= 2'b00;
    else
      link_rst_sync_reg <= {link_rst_sync_reg[0], 1'b1};
  end

  logic sys_rst_n_int;
  logic link_rst_n_int;
  assign sys_rst_n_int = sys_rst_sync_reg[1];
  assign link_rst_n_int = link_rst_sync_reg[1];

  // link domain reset output
  always_ff @(posedge link_clk or negedge link_rst_n_int) begin
    if (!link_rst_n_int)
      mac_reset_link <= 1'b1;
    else
      mac_reset_link <= 1'b0;
  end

  // link domain released flag crosses over to system side as a level
  logic link_up_reg;
  always_ff @(posedge link_clk or negedge link_rst_n_int) begin
    if (!link_rst_n_int)
      link_up_reg <= 1'b0;
    else
      link_up_reg <= 1'b1;
  end

  logic [1:0] link_up_sync_reg;
  always_ff @(posedge sys_clk or negedge sys_rst_n_int) begin
    if (!sys_rst_n_int)
      link_up_sync_reg <= 2'b00;
    else
      link_up_sync_reg <= {link_up_sync_reg[0], link_up_reg};
  end

  // system reset output
  always_ff @(posedge sys_clk or negedge sys_rst_n_int) begin
    if (!sys_rst_n_int)
      mac_reset_sys <= 1'b1;
    else
      mac_reset_sys <= 1'b0;
  end

  // pin input synchronisers
  logic [1:0] gig_sync_reg;
  logic [1:0] ten_sync_reg;
  logic [1:0] mgmt_sync_reg;
  always_ff @(posedge sys_clk or negedge sys_rst_n_int) begin
    if (!sys_rst_n_int) begin
      gig_sync_reg <= 2'b00;
      ten_sync_reg <= 2'b00;
      mgmt_sync_reg <= 2'b11;
    end else begin
      gig_sync_reg <= {gig_sync_reg[0], gigabit_mode};
      ten_sync_reg <= {ten_sync_reg[0], ten_mb_mode};
      mgmt_sync_reg <= {mgmt_sync_reg[0], mgmt_data_in};
    end
  end

  // settle counter: thirty cycles of the slow clock after link released
  logic [5:0] settle_reg;
  logic slow_prev_reg;
  always_ff @(posedge sys_clk or negedge sys_rst_n_int) begin
    if (!sys_rst_n_int) begin
      settle_reg <= '0;
      slow_prev_reg <= 1'b0;
      access_ready <= 1'b0;
    end else begin
      slow_prev_reg <= slow_mac_clk;
      if (!link_up_sync_reg[1])
        settle_reg <= '0;
      else if (slow_mac_clk && !slow_prev_reg && settle_reg != 6'(macrst_pkg::SETTLE_CYCLES))
        settle_reg <= settle_reg + 6'h01;
      access_ready <= (settle_reg == 6'(macrst_pkg::SETTLE_CYCLES));
    end
  end

  // 2.5 mhz mac interface clock divided from system clock
  logic [4:0] slow_div_reg;
  always_ff @(posedge sys_clk or negedge sys_rst_n_int) begin
    if (!sys_rst_n_int) begin
      slow_div_reg <= '0;
      slow_mac_clk <= 1'b0;
    end else if (slow_div_reg == 5'(macrst_pkg::SLOW_DIV_HALF - 1)) begin
      slow_div_reg <= '0;
      slow_mac_clk <= ~slow_mac_clk;
    end else begin
      slow_div_reg <= slow_div_reg + 5'h01;
    end
  end

  // gigabit clock select follows synchronised gigabit pin at any time, held low in 10 mb/s or without gmii/mii
  always_ff @(posedge sys_clk or negedge sys_rst_n_int) begin
    if (!sys_rst_n_int)
      gigabit_clk_sel <= 1'b0;
    else if (phy_interface_select == macrst_pkg::PHY_GMII_MII && !ten_sync_reg[1])
      gigabit_clk_sel <= gig_sync_reg[1];
    else
      gigabit_clk_sel <= 1'b0;
  end

  // phy reset hold then access block
  logic [cnt_w-1:0] phy_cnt_reg;
  always_ff @(posedge sys_clk or negedge sys_rst_n_int) begin
    if (!sys_rst_n_int) begin
      phy_cnt_reg <= '0;
      phy_reset_out_n <= 1'b0;
      phy_access_ready <= 1'b0;
    end else begin
      if (phy_cnt_reg != cnt_w'(rst_cycles + blk_cycles))
        phy_cnt_reg <= phy_cnt_reg + 1'b1;
      phy_reset_out_n <= (phy_cnt_reg >= cnt_w'(rst_cycles));
      phy_access_ready <= (phy_cnt_reg == cnt_w'(rst_cycles + blk_cycles));
    end
  end

  // static configuration outputs and synchronised management data
  always_ff @(posedge sys_clk or negedge sys_rst_n_int) begin
    if (!sys_rst_n_int) begin
      mgmt_data_eff <= 1'b1;
      serdes_flavour_eff <= 1'b0;
      pin_buffers_eff <= 1'b0;
      phy_addr_out <= macrst_pkg::DEFAULT_PHY_ADDR;
    end else begin
      mgmt_data_eff <= internal_pcs ? 1'b1 : mgmt_sync_reg[1];
      serdes_flavour_eff <= internal_pcs ? serdes_flavour_select : 1'b0;
      pin_buffers_eff <= internal_pcs ? 1'b0 : include_pin_buffers;
      phy_addr_out <= internal_phy_mgmt_address;
    end
  end

  // half duplex inputs deliberately unused
  logic unused_half_duplex;
  assign unused_half_duplex = phy_collision ^ phy_carrier_sense;

  // remaining build options only shape datapath outside this block
  logic unused_opts;
  assign unused_opts = tx_tag_insert_en ^ rx_tag_insert_en ^ tx_tag_translate_en ^ rx_tag_translate_en ^
    tx_tag_strip_en ^ rx_tag_strip_en ^ extended_group_filter_en;
endmodule

// ==== macrst_core_checker.sv ====
// assertions on the mac reset sequencing ports
`timescale 1ns/1ps
module macrst_core_checker #(
  parameter int prst_cycles = 20,
  parameter int pblk_cycles = 10
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic tx_data_stream_reset_n,
  input wire logic tx_ctrl_stream_reset_n,
  input wire logic rx_data_stream_reset_n,
  input wire logic rx_status_stream_reset_n,
  input wire logic regbus_reset_n,
  input wire logic gigabit_mode,
  input wire logic ten_mb_mode,
  input wire logic mgmt_data_in,
  input wire logic mac_reset_sys,
  input wire logic mac_reset_link,
  input wire logic access_ready,
  input wire logic phy_reset_out_n,
  input wire logic phy_access_ready,
  input wire logic gigabit_clk_sel,
  input wire logic slow_mac_clk,
  input wire logic mgmt_data_eff
);
  logic all_n;
  logic slow_q;
  logic [4:0] run;
  logic [5:0] rises;
  logic [7:0] cyc;
  // any low reset input
  assign all_n = rst_n & tx_data_stream_reset_n & tx_ctrl_stream_reset_n & rx_data_stream_reset_n
    & rx_status_stream_reset_n & regbus_reset_n;
  // slow clock edges and cycles since release
  always_ff @(posedge sys_clk or negedge all_n) begin
    if (!all_n) begin
      slow_q <= 1'b0;
      run <= 5'h1f;
      rises <= 6'h00;
      cyc <= 8'h00;
    end else begin
      slow_q <= slow_mac_clk;
      if (slow_mac_clk != slow_q)
        run <= 5'h00;
      else if (run != 5'h1f)
        run <= run + 5'h01;
      if (slow_mac_clk && !slow_q && rises != 6'h3f)
        rises <= rises + 6'h01;
      if (cyc != 8'hff)
        cyc <= cyc + 8'h01;
    end
  end
  sequence s_held;
    $rose(all_n) ##0 mac_reset_sys [*2];
  endsequence
  AST_ANY_SYS: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !all_n |-> mac_reset_sys && !access_ready && !phy_reset_out_n) else $error("mac not held");
  AST_ANY_LINK: assert property (@(posedge link_clk) disable iff (!rst_n)
    !all_n |-> mac_reset_link) else $error("link side not held");
  AST_REL_SYS: assert property (@(posedge sys_clk) disable iff (!all_n)
    s_held |-> ##[1:3] !mac_reset_sys) else $error("sys release timing");
  AST_REL_LINK: assert property (@(posedge link_clk) disable iff (!all_n)
    $rose(all_n) |-> mac_reset_link ##[1:6] !mac_reset_link) else $error("link release timing");
  AST_SLOW_CLK: assert property (@(posedge sys_clk) disable iff (!all_n)
    slow_mac_clk != slow_q && run != 5'h1f |-> run == 5'd9) else $error("slow clock period");
  AST_ACCESS: assert property (@(posedge sys_clk) disable iff (!all_n)
    access_ready |-> rises >= 6'd30) else $error("access too early");
  AST_PHY_HOLD: assert property (@(posedge sys_clk) disable iff (!all_n)
    cyc < prst_cycles |-> !phy_reset_out_n) else $error("phy reset short");
  AST_PHY_BLOCK: assert property (@(posedge sys_clk) disable iff (!all_n)
    cyc < prst_cycles + pblk_cycles |-> !phy_access_ready) else $error("phy block short");
  AST_CLK_SEL: assert property (@(posedge sys_clk) disable iff (!all_n)
    (gigabit_mode && !ten_mb_mode) [*8] |-> gigabit_clk_sel) else $error("gigabit not chosen");
  AST_MGMT: assert property (@(posedge sys_clk) disable iff (!all_n)
    (!mgmt_data_in) [*8] |-> !mgmt_data_eff) else $error("mgmt input lost");
endmodule
bind macrst_core macrst_core_checker #(.prst_cycles(phy_reset_cycles), .pblk_cycles(phy_block_cycles)) u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk), .tx_data_stream_reset_n(tx_data_stream_reset_n),
  .tx_ctrl_stream_reset_n(tx_ctrl_stream_reset_n), .rx_data_stream_reset_n(rx_data_stream_reset_n),
  .rx_status_stream_reset_n(rx_status_stream_reset_n), .regbus_reset_n(regbus_reset_n),
  .gigabit_mode(gigabit_mode), .ten_mb_mode(ten_mb_mode), .mgmt_data_in(mgmt_data_in),
  .mac_reset_sys(mac_reset_sys), .mac_reset_link(mac_reset_link), .access_ready(access_ready),
  .phy_reset_out_n(phy_reset_out_n), .phy_access_ready(phy_access_ready),
  .gigabit_clk_sel(gigabit_clk_sel), .slow_mac_clk(slow_mac_clk), .mgmt_data_eff(mgmt_data_eff));

// ==== macrst_phy_model.sv ====
// behavioural phy on the far side of the mac
`timescale 1ns/1ps
module macrst_phy_model (
  input wire logic mgmt_drive_en,
  input wire logic mgmt_drive_val,
  output logic link_clk = 1'b0,
  output logic phy_collision = 1'b0,
  output logic phy_carrier_sense = 1'b0,
  output wire logic mgmt_data_in
);
  // free running transmit clock, 48 ns
  always #24 link_clk = ~link_clk;
  // half duplex pins wiggle, mac ignores them
  always @(posedge link_clk) begin
    phy_collision <= ~phy_collision;
    phy_carrier_sense <= phy_collision;
  end
  // pulled up management line unless driven
  assign mgmt_data_in = mgmt_drive_en ? mgmt_drive_val : 1'b1;
endmodule

// ==== tb_mac_reset_and_build_config.sv ====
// self-checking bench for the mac reset and build configuration block
`timescale 1ns/1ps
module tb_mac_reset_and_build_config;
  logic sys_clk, rst_n, gigabit_mode, ten_mb_mode, mgmt_drive_en, mgmt_drive_val;
  logic [4:0] dom_n;
  wire logic link_clk, phy_collision, phy_carrier_sense, mgmt_data_in;
  logic mac_reset_sys, mac_reset_link, access_ready, phy_reset_out_n, phy_access_ready;
  logic gigabit_clk_sel, slow_mac_clk, mgmt_data_eff, serdes_flavour_eff, pin_buffers_eff;
  logic [4:0] phy_addr_out;
  integer seed = 32'hf46f5eff;
  int n_mismatch = 0;
  int checked = 0;
  int i, t;
  logic [1:0] m;
  time t0;
  // legal build: tri-mode soft mac on gmii, timed media mode off
  macrst_core #(.mac_variant_select(macrst_pkg::VARIANT_SOFT_TRI), .internal_phy_mgmt_address(5'h1f),
    .phy_reset_cycles(20), .phy_block_cycles(10)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk), .tx_data_stream_reset_n(dom_n[0]),
    .tx_ctrl_stream_reset_n(dom_n[1]), .rx_data_stream_reset_n(dom_n[2]), .rx_status_stream_reset_n(dom_n[3]),
    .regbus_reset_n(dom_n[4]), .gigabit_mode(gigabit_mode), .ten_mb_mode(ten_mb_mode),
    .phy_collision(phy_collision), .phy_carrier_sense(phy_carrier_sense), .mgmt_data_in(mgmt_data_in),
    .mac_reset_sys(mac_reset_sys), .mac_reset_link(mac_reset_link), .access_ready(access_ready),
    .phy_reset_out_n(phy_reset_out_n), .phy_access_ready(phy_access_ready), .gigabit_clk_sel(gigabit_clk_sel),
    .slow_mac_clk(slow_mac_clk), .mgmt_data_eff(mgmt_data_eff), .serdes_flavour_eff(serdes_flavour_eff),
    .pin_buffers_eff(pin_buffers_eff), .phy_addr_out(phy_addr_out));
  macrst_phy_model phy (.mgmt_drive_en(mgmt_drive_en), .mgmt_drive_val(mgmt_drive_val), .link_clk(link_clk),
    .phy_collision(phy_collision), .phy_carrier_sense(phy_carrier_sense), .mgmt_data_in(mgmt_data_in));
  // expected clock select and first legal access cycle
  function automatic logic exp_sel(input logic g, input logic ten);
    return g & ~ten;
  endfunction
  function automatic int ready_min();
    return 10 + 29 * 20;
  endfunction
  task automatic check(input logic [4:0] seen, input logic [4:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // wait for access after a release, bounded
  task automatic await_ready();
    t = 0;
    while (access_ready !== 1'b1 && t < 2000) begin
      @(negedge sys_clk);
      t++;
    end
    check({t >= ready_min(), t < ready_min() + 80}, 2'b11);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // watchdog
  initial begin
    #400000;
    n_mismatch++;
    conclude();
  end
  initial begin
    rst_n = 1'b0;
    dom_n = 5'h1f;
    gigabit_mode = 1'b0;
    ten_mb_mode = 1'b0;
    mgmt_drive_en = 1'b0;
    mgmt_drive_val = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 check({mac_reset_sys, access_ready, phy_reset_out_n}, 3'b100);
    @(posedge sys_clk);
    rst_n <= 1'b1;
    await_ready();
    check(phy_addr_out, 5'h1f);
    check({pin_buffers_eff, serdes_flavour_eff, phy_reset_out_n, phy_access_ready}, 4'b1011);
    $display("power up test done");
    for (i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      dom_n[i] <= 1'b0;
      repeat (3 + $unsigned($random(seed)) % 3) @(posedge sys_clk);
      #1 check({mac_reset_sys, mac_reset_link, access_ready, phy_reset_out_n}, 4'b1100);
      @(posedge sys_clk);
      dom_n[i] <= 1'b1;
      await_ready();
    end
    $display("domain reset test done");
    for (i = 0; i < 8; i++) begin
      m = 2'($random(seed));
      @(posedge sys_clk);
      gigabit_mode <= i[0];
      ten_mb_mode <= i[1];
      mgmt_drive_en <= 1'b1;
      mgmt_drive_val <= m[0];
      repeat (8) @(posedge sys_clk);
      #1 check({gigabit_clk_sel, mgmt_data_eff}, {exp_sel(i[0], i[1]), m[0]});
    end
    $display("clock select test done");
    @(posedge slow_mac_clk);
    t0 = $time;
    @(posedge slow_mac_clk);
    check(5'(($time - t0) / 20), 5'd20);
    $display("slow clock test done");
    conclude();
  end
endmodule
